// *** include/chb_pkg.sv ***
// Package: constants and types for the cascadable lookup host port.
// Assumes a single clock domain and a synchronous active-low reset.
package chb_pkg;

  // ------------------------------------------------------------
  // Bus and register layout
  // ------------------------------------------------------------
  localparam int unsigned DAT_W = 33;
  localparam int unsigned ADR_W = 4;
  localparam int unsigned REG_W = 9;
  localparam logic [3:0] TESTMODE_ADR = 4'h7;
  localparam logic [3:0] STATUS_ADR_LO = 4'h6;
  localparam logic [3:0] CMD_ADR = 4'h0;
  // Testmode word fields
  localparam int unsigned SEL_LSB = 11;
  localparam int unsigned CTL_READ_BIT = 10;
  localparam int unsigned CTL_SLAVE_BIT = 9;
  // Selection codes
  localparam logic [2:0] SEL_MODE = 3'h0;
  localparam logic [2:0] SEL_TCFG = 3'h1;
  localparam logic [2:0] SEL_TEST_MULTIPLEXER_REGISTER = 3'h2;
  localparam logic [2:0] SEL_VERSION_OCTET_0 = 3'h4;
  // Mode and test configuration bit positions
  localparam int unsigned MODE_DUP_BIT = 8;
  localparam int unsigned TCFG_SRCH_BIT = 0;
  localparam int unsigned TCFG_READ_BIT = 1;
  localparam int unsigned TCFG_WRITE_BIT = 2;
  localparam logic [8:0] MODE_RST = 9'h000;
  localparam logic [8:0] TCFG_RST = 9'h000;
  localparam logic [8:0] TEST_MULTIPLEXER_REGISTER_RST = 9'h000;
  // Arbitrary version code, not tied to any part
  localparam logic [31:0] VERSION_CODE = 32'h0403_0201;
  // Request layout in the command word
  localparam int unsigned REQ_LSB = 28;
  localparam int unsigned LCI_W = 14;
  localparam logic [13:0] SLAVE_LCI_BASE = 14'h2000;
  // Processing time of a request in cycles
  localparam logic [3:0] BUSY_CYCLES = 4'h8;
  localparam logic [3:0] XCHG_CYCLE = 4'h4;

  // ------------------------------------------------------------
  // Cascade codes
  // ------------------------------------------------------------
  localparam logic [1:0] CAS_MISS = 2'h0;
  localparam logic [1:0] CAS_HIT = 2'h1;
  localparam logic [1:0] CAS_IDLE = 2'h2;
  localparam logic [1:0] CAS_NOSRCH = 2'h3;

  typedef enum logic [4:0] {
    CHB_IDLE = 5'b00001,
    CHB_SRCH = 5'b00010,
    CHB_NSRCH = 5'b00100,
    CHB_DONE = 5'b01000,
    CHB_PERR = 5'b10000
  } chb_state_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_NORMAL = 4'h1,
    OP_PAR_WRITE = 4'h2,
    OP_PAR_READ = 4'h3,
    OP_PAR_SEARCH = 4'h4,
    OP_DUP_SEARCH = 4'h5
  } chb_op_t;

  typedef enum logic [3:0] {
    ST_OK = 4'h0,
    ST_BUSY = 4'h4,
    ST_ALARM_HIT = 4'h8,
    ST_ALARM_REFUSED = 4'h9,
    ST_ERR_PARITY = 4'hc,
    ST_ERR_CASCADE = 4'hd,
    ST_ERR_CMD = 4'he
  } chb_status_t;

endpackage : chb_pkg

// *** include/chb_cfg_if.sv ***
// Interface: configuration register port between the host port and the
// register bank. Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface chb_cfg_if;
  logic wr_en;
  logic [2:0] sel;
  logic [8:0] wdata;
  logic [8:0] rdata;
  logic [8:0] mode;
  logic [8:0] tcfg;
  logic [2:0] cas_in;

  modport port (output wr_en, output sel, output wdata, output cas_in,
                input rdata, input mode, input tcfg);
  modport bank (input wr_en, input sel, input wdata, input cas_in,
                output rdata, output mode, output tcfg);
endinterface : chb_cfg_if
`default_nettype wire

// *** src/chb_regs.sv ***
// Register bank reached through the testmode word selection field.
// Assumes writes arrive only from the host port in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module chb_regs
  import chb_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  chb_cfg_if.bank cfg
);

  logic [8:0] mode_q;
  logic [8:0] tcfg_q;
  logic [8:0] test_multiplexer_register_q;
  logic [8:0] rdata_q;
  logic [7:0] ver_oct;

  // ------------------------------------------------------------
  // Writable registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_q <= MODE_RST;
      tcfg_q <= TCFG_RST;
      test_multiplexer_register_q <= TEST_MULTIPLEXER_REGISTER_RST;
    end else if (cfg.wr_en) begin
      case (cfg.sel)
        SEL_MODE: mode_q <= cfg.wdata;
        SEL_TCFG: tcfg_q <= cfg.wdata;
        SEL_TEST_MULTIPLEXER_REGISTER: test_multiplexer_register_q <= cfg.wdata;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read data, registered
  // ------------------------------------------------------------
  always_comb begin
    ver_oct = VERSION_CODE[8 * cfg.sel[1:0] +: 8];
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= 9'h000;
    end else begin
      case (cfg.sel)
        SEL_MODE: rdata_q <= mode_q;
        SEL_TCFG: rdata_q <= tcfg_q;
        SEL_TEST_MULTIPLEXER_REGISTER: rdata_q <= test_multiplexer_register_q;
        3'h3: rdata_q <= {6'h00, cfg.cas_in};
        default: rdata_q <= {1'b0, ver_oct};
      endcase
    end
  end

  assign cfg.rdata = rdata_q;
  assign cfg.mode = mode_q;
  assign cfg.tcfg = tcfg_q;

endmodule : chb_regs
`default_nettype wire

// *** src/chb_host_port.sv ***
// Host bus port, test configuration decode and two-chip cascade logic.
// Assumes host inputs synchronous to clk_in; the board resolves the data
// bus from data_lines_oe_out.
//
// What this block does
// - Duplicate check set: search both chips first, refuse write on hit.
// - Parallel-write bit turns write request 4 into all-bank write.
// - Parallel-read bit turns read request 5 into all-bank read.
// - Parallel-search bit turns search request 3 into all-bank search.
// - Four read-only version octets, bit 8 reads zero.
// - Access only when chip select low at edge; write strobe picks direction.
// - Output enable gates data drivers, only during reads.
// - Bus width select low means 16 bits, else 32; held static.
// - Data line 0 gives odd parity over data and address lines.
// - In 16-bit mode upper data ignored on write, zero on read.
// - Both chips process each request; responder fixed or by search result.
// - During search each chip reports local result on cascade outputs 1..0.
// - Role strap 0 is master ids 0..8191, 1 slave 8192..16383.
// - Cascade outputs: 00 miss, 01 match, 10 idle, 11 requests 4..6.
// - Cascade inputs read with the same codes as the opposite chip state.
// - Master ignores cascade input 2; slave drives reads only when it is 1.
// - Master cascade output 2 low forbids slave read output, high allows.
// - During reset data bus undriven and cascade outputs 000.
`timescale 1ns/1ps
`default_nettype none
module chb_host_port
  import chb_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Host bus
  input wire logic chip_sel_n_in,
  input wire logic write_n_in,
  input wire logic out_en_n_in,
  input wire logic [3:0] adr_in,
  input wire logic bus_width_select_in,
  input wire logic [32:0] data_lines_in,
  output logic [32:0] data_lines_out,
  output logic data_lines_oe_out,
  // Cascade link
  input wire logic cascade_role_select_in,
  input wire logic [2:0] cascade_in,
  output logic [2:0] cascade_out,
  // Core side: request launch and local result
  input wire logic local_match_in,
  output logic [3:0] op_kind_out,
  output logic op_start_out,
  output logic [13:0] local_connection_id_out,
  output logic respond_out
);

  chb_cfg_if cfg ();

  chb_state_t state_q, state_d;
  chb_status_t status_q;
  logic [3:0] cnt_q;
  logic [3:0] req_q;
  logic [13:0] lci_q;
  logic [3:0] op_q;
  logic start_q;
  logic respond_q;
  logic read_q;
  logic read_drive;
  logic [32:0] rdata_q;
  logic [2:0] sel_q;
  logic cmd_slave_q;
  logic par_ok;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic [31:0] wdat;
  logic is_srch;
  logic own_req;
  logic slave_gate;
  logic local_hit_q;
  logic [1:0] co_q;
  logic co2_q;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic odd_par_ok(input logic [32:0] d,
                                      input logic [3:0] a,
                                      input logic wide);
    logic [32:0] m;
    m = wide ? d : {16'h0000, d[16:0]};
    return ^{m, a};
  endfunction : odd_par_ok

  function automatic logic in_own_range(input logic [13:0] local_connection_id,
                                        input logic slave);
    return (local_connection_id >= SLAVE_LCI_BASE) == slave;
  endfunction : in_own_range

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  assign acc = !chip_sel_n_in;
  assign wr_acc = acc && !write_n_in;
  assign rd_acc = acc && write_n_in;
  // Upper half dropped in narrow mode
  // Word bits sit one line above the parity line
  assign wdat = bus_width_select_in ? data_lines_in[32:1]
              : {16'h0000, data_lines_in[16:1]};
  assign par_ok = odd_par_ok(data_lines_in, adr_in,
                             bus_width_select_in);
  assign is_srch = (req_q >= 4'h1 && req_q <= 4'h3) ||
                   (req_q == 4'h4 && cfg.mode[MODE_DUP_BIT]);

  // Test word write into the register bank
  assign cfg.wr_en = wr_acc && par_ok && (adr_in == TESTMODE_ADR)
                     && !wdat[CTL_READ_BIT]
                     && !wdat[SEL_LSB + 2]
                     && (wdat[CTL_SLAVE_BIT]
                         == cascade_role_select_in)
                     && (state_q == CHB_IDLE || state_q == CHB_DONE);
  // Held selection feeds the registered read data between test words
  assign cfg.sel = cfg.wr_en ? wdat[SEL_LSB +: 3] : sel_q;
  assign cfg.wdata = wdat[8:0];
  assign cfg.cas_in = cascade_in;

  chb_regs u_regs (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .cfg(cfg)
  );

  // ------------------------------------------------------------
  // Request sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      CHB_IDLE, CHB_DONE: begin
        if (wr_acc && !par_ok) begin
          state_d = CHB_PERR;
        end else if (wr_acc && adr_in == CMD_ADR) begin
          state_d = ((wdat[REQ_LSB +: 4] >= 4'h1 &&
                      wdat[REQ_LSB +: 4] <= 4'h3) ||
                     (wdat[REQ_LSB +: 4] == 4'h4 &&
                      cfg.mode[MODE_DUP_BIT])) ? CHB_SRCH : CHB_NSRCH;
        end
      end
      CHB_SRCH, CHB_NSRCH: begin
        if (cnt_q == BUSY_CYCLES) begin
          state_d = CHB_DONE;
        end
      end
      CHB_PERR: begin
        // Left only by reading status
        if (rd_acc && adr_in[2:0] == STATUS_ADR_LO[2:0]) begin
          state_d = CHB_IDLE;
        end
      end
      default: state_d = CHB_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= CHB_IDLE;
      cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_d == CHB_SRCH || state_d == CHB_NSRCH)
               && state_q == state_d ? cnt_q + 4'h1 : 4'h0;
    end
  end

  // Latch request and pick operation; both chips take every request
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      req_q <= 4'h0;
      lci_q <= 14'h0000;
      op_q <= OP_NONE;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if ((state_q == CHB_IDLE || state_q == CHB_DONE) &&
          (state_d == CHB_SRCH || state_d == CHB_NSRCH)) begin
        req_q <= wdat[REQ_LSB +: 4];
        lci_q <= wdat[LCI_W-1:0];
        start_q <= 1'b1;
        if (wdat[REQ_LSB +: 4] == 4'h4 && cfg.mode[MODE_DUP_BIT]) begin
          op_q <= OP_DUP_SEARCH;
        end else if (wdat[REQ_LSB +: 4] == 4'h4 &&
                     cfg.tcfg[TCFG_WRITE_BIT]) begin
          op_q <= OP_PAR_WRITE;
        end else if (wdat[REQ_LSB +: 4] == 4'h5 &&
                     cfg.tcfg[TCFG_READ_BIT]) begin
          op_q <= OP_PAR_READ;
        end else if (wdat[REQ_LSB +: 4] == 4'h3 &&
                     cfg.tcfg[TCFG_SRCH_BIT]) begin
          op_q <= OP_PAR_SEARCH;
        end else begin
          op_q <= OP_NORMAL;
        end
      end
    end
  end

  // Test word read/slave selection, held for the read that follows
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cmd_slave_q <= 1'b0;
      sel_q <= SEL_MODE;
    end else if (wr_acc && par_ok && adr_in == TESTMODE_ADR) begin
      cmd_slave_q <= wdat[CTL_SLAVE_BIT];
      sel_q <= wdat[SEL_LSB +: 3];
    end
  end

  // ------------------------------------------------------------
  // Local result, cascade outputs and responder choice
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      local_hit_q <= 1'b0;
    end else if (start_q) begin
      local_hit_q <= 1'b0;
    end else if (state_q == CHB_SRCH && cnt_q == XCHG_CYCLE) begin
      local_hit_q <= local_match_in;
    end
  end

  always_comb begin
    if (req_q == 4'h6) begin
      own_req = cmd_slave_q == cascade_role_select_in;
    end else begin
      own_req = in_own_range(lci_q, cascade_role_select_in);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      co_q <= 2'h0;
    end else begin
      case (state_d)
        CHB_SRCH: co_q <= local_hit_q ? CAS_HIT : CAS_MISS;
        CHB_NSRCH: co_q <= CAS_NOSRCH;
        default: co_q <= CAS_IDLE;
      endcase
    end
  end

  // Master gates slave reads; parity trouble keeps the slave quiet
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      co2_q <= 1'b0;
    end else begin
      co2_q <= !cascade_role_select_in && state_d != CHB_PERR
               && !own_req;
    end
  end
  assign cascade_out = {co2_q, co_q};

  // Decide who answers once the request ends
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      respond_q <= 1'b0;
      status_q <= ST_OK;
    end else if (start_q) begin
      respond_q <= 1'b0;
      status_q <= ST_BUSY;
    end else if (state_q == CHB_PERR) begin
      status_q <= ST_ERR_PARITY;
    end else if (state_q != CHB_DONE && state_d == CHB_DONE) begin
      if (is_srch) begin
        if (req_q == 4'h4) begin
          // Checked write still answers by its id range
          respond_q <= own_req;
        end else if (!cascade_role_select_in) begin
          respond_q <= local_hit_q || cascade_in[1:0] != CAS_HIT;
        end else begin
          respond_q <= local_hit_q && cascade_in[1:0] == CAS_MISS;
        end
        if (!cascade_role_select_in && cascade_in[1]) begin
          status_q <= ST_ERR_CASCADE;
        end else if (req_q == 4'h4 &&
                     (local_hit_q || cascade_in[1:0] == CAS_HIT)) begin
          status_q <= ST_ALARM_REFUSED;
        end else if (local_hit_q && cascade_in[1:0] == CAS_HIT) begin
          status_q <= ST_ALARM_HIT;
        end else begin
          status_q <= ST_OK;
        end
      end else begin
        respond_q <= own_req;
        status_q <= (!cascade_role_select_in &&
                     cascade_in[1:0] == CAS_IDLE) ? ST_ERR_CASCADE
                                                  : ST_OK;
      end
    end
  end

  // Core launch; a duplicate hit leaves the line untouched
  assign op_start_out = start_q;
  assign op_kind_out = op_q;
  assign local_connection_id_out = lci_q;
  assign respond_out = respond_q && status_q != ST_ALARM_REFUSED;

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      read_q <= 1'b0;
      rdata_q <= 33'h0;
    end else begin
      read_q <= rd_acc;
      if (rd_acc) begin
        if (adr_in[2:0] == STATUS_ADR_LO[2:0]) begin
          rdata_q[32:1] <= {28'h0, status_q};
        end else if (adr_in == TESTMODE_ADR) begin
          rdata_q[32:1] <= {23'h0, cfg.rdata};
        end else begin
          rdata_q[32:1] <= 32'h0;
        end
      end
    end
  end

  // Parity bit completes lines to odd; narrow mode zeroes upper half
  always_comb begin
    data_lines_out = bus_width_select_in ? rdata_q
                   : {16'h0000, rdata_q[16:0]};
    data_lines_out[0] = ~^{data_lines_out[32:1], adr_in};
  end

  // Slave output gated by cascade input 2; master ignores it
  assign slave_gate = !cascade_role_select_in || cascade_in[2];
  assign read_drive = read_q && !out_en_n_in;
  assign data_lines_oe_out = rst_n_in && read_drive && slave_gate;

endmodule : chb_host_port
`default_nettype wire

// *** test/chb_peer_model.sv ***
// Model of the opposite cascaded chip, seen only at its cascade pins.
// Assumes it follows the same requests as the design; it never matches.
`timescale 1ns/1ps
`default_nettype none
module chb_peer_model
  import chb_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control from the bench
  input wire logic is_master_in,
  input wire logic permit_in,
  // Cascade link
  input wire logic [2:0] far_out_in,
  output logic [2:0] cascade_out
);
  // ------------------------------------------------------------
  // Cascade state report
  // ------------------------------------------------------------
  logic tog_q;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cascade_out <= 3'h0;
      tog_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
      // Same request as the far chip; a search here always misses
      cascade_out[1:0] <= (far_out_in[1:0] == CAS_NOSRCH) ? CAS_NOSRCH :
        (far_out_in[1] ? CAS_IDLE : CAS_MISS);
      // A slave's permit line is undefined, so it toggles
      cascade_out[2] <= is_master_in ? permit_in : tog_q;
    end
  end
endmodule : chb_peer_model
`default_nettype wire

// *** test/chb_host_port_chk.sv ***
// Checker: port-level properties of the host port.
// Assumes binding to chb_host_port, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module chb_host_port_chk
  import chb_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Host bus
  input wire logic chip_sel_n_in,
  input wire logic write_n_in,
  input wire logic out_en_n_in,
  input wire logic [3:0] adr_in,
  input wire logic bus_width_select_in,
  input wire logic [32:0] data_lines_out,
  input wire logic data_lines_oe_out,
  // Cascade and core side
  input wire logic cascade_role_select_in,
  input wire logic [2:0] cascade_in,
  input wire logic [2:0] cascade_out,
  input wire logic [3:0] op_kind_out,
  input wire logic op_start_out
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  AST_RST_CAS: assert property (disable iff (1'b0)
    !rst_n_in |=> cascade_out == 3'h0) else $error("cascade not cleared");
  AST_RST_OE: assert property (disable iff (1'b0)
    !rst_n_in |=> !data_lines_oe_out) else $error("bus driven in reset");
  AST_IDLE: assert property ($rose(rst_n_in) |=>
    cascade_out[1:0] == CAS_IDLE) else $error("not idle after reset");
  AST_OE_CAUSE: assert property (data_lines_oe_out |->
    !out_en_n_in && $past(!chip_sel_n_in && write_n_in))
    else $error("drive without read");
  AST_OE_MASTER: assert property (!cascade_role_select_in
    && !out_en_n_in && $past(!chip_sel_n_in && write_n_in)
    |-> data_lines_oe_out) else $error("master read not driven");
  AST_SLAVE_GATE: assert property (cascade_role_select_in
    && !cascade_in[2] && !$past(cascade_in[2]) |-> !data_lines_oe_out)
    else $error("slave drove without permit");
  AST_PARITY: assert property (data_lines_oe_out |-> ^{
    bus_width_select_in ? data_lines_out[32:17] : 16'h0,
    data_lines_out[16:0], adr_in}) else $error("read parity not odd");
  AST_UPPER16: assert property (data_lines_oe_out
    && !bus_width_select_in |-> data_lines_out[32:17] == 16'h0)
    else $error("upper half not zero");
  AST_START: assert property (op_start_out |-> $past(!chip_sel_n_in
    && !write_n_in && adr_in == CMD_ADR)) else $error("start uncaused");
  AST_BUSY: assert property (op_start_out |->
    (cascade_out[1:0] != CAS_IDLE) [*8]) else $error("idle while busy");
  AST_NOSRCH: assert property (op_start_out &&
    (op_kind_out == OP_PAR_WRITE || op_kind_out == OP_PAR_READ)
    |-> cascade_out[1:0] == CAS_NOSRCH) else $error("bad non-search code");
  AST_SRCH: assert property (op_start_out &&
    op_kind_out == OP_PAR_SEARCH |-> !cascade_out[1])
    else $error("bad search code");
endmodule : chb_host_port_chk

bind chb_host_port chb_host_port_chk u_chk (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .chip_sel_n_in(chip_sel_n_in),
  .write_n_in(write_n_in), .out_en_n_in(out_en_n_in), .adr_in(adr_in),
  .bus_width_select_in(bus_width_select_in),
  .data_lines_out(data_lines_out), .data_lines_oe_out(data_lines_oe_out),
  .cascade_role_select_in(cascade_role_select_in),
  .cascade_in(cascade_in), .cascade_out(cascade_out),
  .op_kind_out(op_kind_out), .op_start_out(op_start_out));
`default_nettype wire

// *** test/chb_host_port_test.sv ***
// Testbench: host bus accesses, requests and cascade roles.
// Assumes the peer model on the cascade link and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module chb_host_port_test
  import chb_pkg::*;
;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cs_n = 1'b1;
  logic we_n = 1'b1;
  logic oe_n = 1'b0;
  logic [3:0] adr = 4'h0;
  logic bw = 1'b1;
  logic [32:0] dat = 33'h0;
  logic role = 1'b0;
  logic permit = 1'b0;
  logic lm = 1'b0;
  logic [2:0] cin;
  logic [2:0] cout;
  logic [32:0] dout;
  logic doe;
  logic [3:0] kind;
  logic start;
  logic resp;
  logic [32:0] q;
  logic qoe;
  logic [8:0] tc;
  logic [8:0] v;
  logic bad = 1'b0;
  logic alone = 1'b0;
  logic [2:0] pc;
  logic [13:0] local_connection_id;
  int err_count = 0;
  int n_compared = 0;
  int seed = 32'h08d6;

  chb_host_port DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .chip_sel_n_in(cs_n), .write_n_in(we_n), .out_en_n_in(oe_n),
    .adr_in(adr), .bus_width_select_in(bw), .data_lines_in(dat),
    .data_lines_out(dout), .data_lines_oe_out(doe),
    .cascade_role_select_in(role), .cascade_in(cin), .cascade_out(cout),
    .local_match_in(lm), .op_kind_out(kind), .op_start_out(start),
    .local_connection_id_out(local_connection_id), .respond_out(resp));
  chb_peer_model u_peer (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .is_master_in(role), .permit_in(permit),
    .far_out_in(cout), .cascade_out(pc));
  // Lone chip: cascade inputs grounded
  assign cin = alone ? 3'h0 : pc;

  initial forever #2.5 clk_in = ~clk_in;

  // ------------------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic tmo();
    err_count++;
    $display("[ERR] %0t wait limit used up", $time);
    stop_test();
  endtask : tmo

  // One access, request held to the sampling edge, then released
  task automatic acc(input logic c, input logic wr, input logic [3:0] a,
                     input logic [31:0] w);
    @(posedge clk_in);
    cs_n <= ~c;
    we_n <= ~wr;
    adr <= a;
    dat <= {w, bad ^ ~^{bw ? w : {16'h0, w[15:0]}, a}};
    @(posedge clk_in);
    cs_n <= 1'b1;
    dat <= ~dat;
    #1;
    q = dout;
    qoe = doe;
  endtask : acc

  task automatic tmw(input logic [2:0] s, input logic r, input logic [8:0] d);
    acc(1'b1, 1'b1, TESTMODE_ADR,
        {bw ? 18'h0 : 18'($random(seed)), s, r, role, d});
  endtask : tmw

  task automatic tmr(input logic [2:0] s);
    tmw(s, 1'b1, 9'h0);
    acc(1'b1, 1'b0, TESTMODE_ADR, 32'h0);
  endtask : tmr

  function automatic chb_op_t exp_op(input logic [3:0] r, input logic d);
    if (d) return OP_DUP_SEARCH;
    if (r == 4'h4 && tc[TCFG_WRITE_BIT]) return OP_PAR_WRITE;
    if (r == 4'h5 && tc[TCFG_READ_BIT]) return OP_PAR_READ;
    if (r == 4'h3 && tc[TCFG_SRCH_BIT]) return OP_PAR_SEARCH;
    return OP_NORMAL;
  endfunction : exp_op

  function automatic logic exp_resp(input logic [3:0] r,
                                    input logic [13:0] id, input logic d);
    if (r < 4'h4) return role ? lm : 1'b1;
    if (d && lm) return 1'b0;
    return id[13] == role;
  endfunction : exp_resp

  task automatic cmd(input logic [3:0] r, input logic [13:0] id,
                     input logic d);
    int i;
    acc(1'b1, 1'b1, CMD_ADR, {r, 14'h0, id});
    for (i = 0; i < 4 && start !== 1'b1; i++) @(posedge clk_in) #1;
    if (i == 4) tmo();
    chk(33'(kind), 33'(exp_op(r, d)));
    chk(33'(local_connection_id), 33'(id));
    for (i = 0; i < 40 && cout[1:0] !== CAS_IDLE; i++) @(posedge clk_in) #1;
    if (i == 40) tmo();
    chk(33'(resp), 33'(exp_resp(r, id, d)));
  endtask : cmd

  task automatic phase(input logic r, input logic w);
    @(posedge clk_in);
    role <= r;
    bw <= w;
    rst_n_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    #1;
    chk(33'({doe, cout}), 33'h0);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk(33'(cout[1:0]), 33'(CAS_IDLE));
  endtask : phase

  task automatic vers();
    for (int k = 0; k < 4; k++) begin
      tmr(3'(SEL_VERSION_OCTET_0 + k));
      chk(33'(q[9:1]), {25'h0, VERSION_CODE[8 * k +: 8]});
      if (!bw) chk(33'(q[32:17]), 33'h0);
    end
  endtask : vers

  task automatic ops();
    logic [13:0] id;
    for (int n = 0; n < 12; n++) begin
      tc = {6'h0, n % 4 == 3, n % 4 == 2, n % 4 == 1};
      id = 14'($random(seed));
      @(posedge clk_in);
      lm <= 1'($random(seed));
      tmw(SEL_TCFG, 1'b0, tc);
      cmd(4'(3 + n % 3), id, 1'b0);
    end
    tc = 9'h0;
    tmw(SEL_TCFG, 1'b0, tc);
    tmw(SEL_MODE, 1'b0, 9'(1 << MODE_DUP_BIT));
    @(posedge clk_in);
    lm <= 1'b1;
    cmd(4'h4, id, 1'b1);
    acc(1'b1, 1'b0, STATUS_ADR_LO, 32'h0);
    chk(33'(q[4:1]), 33'(ST_ALARM_REFUSED));
    @(posedge clk_in);
    lm <= 1'b0;
    cmd(4'h4, id, 1'b1);
    tmw(SEL_MODE, 1'b0, MODE_RST);
  endtask : ops

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    phase(1'b0, 1'b1);
    tmr(SEL_TEST_MULTIPLEXER_REGISTER);
    chk(33'(q[9:1]), 33'(TEST_MULTIPLEXER_REGISTER_RST));
    v = 9'($random(seed));
    tmw(SEL_TEST_MULTIPLEXER_REGISTER, 1'b0, v);
    // Strobe without chip select must leave the register alone
    acc(1'b0, 1'b1, TESTMODE_ADR, {18'h0, SEL_TEST_MULTIPLEXER_REGISTER, 2'b00, ~v});
    tmr(SEL_TEST_MULTIPLEXER_REGISTER);
    chk(33'(q[9:1]), 33'(v));
    tmw(SEL_TEST_MULTIPLEXER_REGISTER, 1'b0, TEST_MULTIPLEXER_REGISTER_RST);
    // Bad parity write is refused until status is read
    bad = 1'b1;
    tmw(SEL_TEST_MULTIPLEXER_REGISTER, 1'b0, 9'h1ff);
    bad = 1'b0;
    acc(1'b1, 1'b0, STATUS_ADR_LO, 32'h0);
    chk(33'(q[4:1]), 33'(ST_ERR_PARITY));
    tmr(SEL_TEST_MULTIPLEXER_REGISTER);
    chk(33'(q[9:1]), 33'(TEST_MULTIPLEXER_REGISTER_RST));
    @(posedge clk_in);
    oe_n <= 1'b1;
    acc(1'b1, 1'b0, TESTMODE_ADR, 32'h0);
    chk(33'(qoe), 33'h0);
    @(posedge clk_in);
    oe_n <= 1'b0;
    vers();
    ops();
    @(posedge clk_in);
    alone <= 1'b1;
    cmd(4'h3, 14'h0155, 1'b0);
    alone <= 1'b0;
    $display("master 32-bit test done");
    phase(1'b0, 1'b0);
    vers();
    $display("master 16-bit test done");
    phase(1'b1, 1'b1);
    tmr(SEL_VERSION_OCTET_0);
    chk(33'(qoe), 33'h0);
    @(posedge clk_in);
    permit <= 1'b1;
    repeat (2) @(posedge clk_in);
    vers();
    chk(33'(qoe), 33'h1);
    tmr(3'h3);
    chk(33'(q[3:1]), {30'h0, permit, CAS_IDLE});
    ops();
    $display("slave 32-bit test done");
    stop_test();
  end
endmodule : chb_host_port_test
`default_nettype wire
